// [rtl/pud_pkg.sv]
// constants, register map and carrier types of the power-up defaults and recovery block
package pud_pkg;

    // clock and recovery times
    localparam int unsigned CLK_MHZ        = 25;
    localparam int unsigned T_REC_SHORT_US = 100;
    localparam int unsigned T_REC_MID_US   = 97000;
    localparam int unsigned T_REC_LONG_US  = 100000;
    localparam int unsigned REC_SHORT_CYC  = T_REC_SHORT_US * CLK_MHZ;
    localparam int unsigned REC_MID_CYC    = T_REC_MID_US * CLK_MHZ;
    localparam int unsigned REC_LONG_CYC   = T_REC_LONG_US * CLK_MHZ;
    localparam int          CNT_W          = 22;

    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_SEC  = 8'h01;
    localparam logic [7:0] IDX_CLK  = 8'h04;
    localparam logic [7:0] IDX_CTRL = 8'h08;
    localparam logic [7:0] IDX_WDOG = 8'h09;
    localparam logic [7:0] IDX_ALM  = 8'h0A;
    localparam logic [7:0] IDX_HALT = 8'h0C;
    localparam logic [7:0] IDX_STAT = 8'h10;

    // field positions
    localparam int OSC_HALT_BIT = 7;
    localparam int REC_SEL_BIT  = 7;
    localparam int OUT_BIT      = 7;
    localparam int FT_BIT       = 6;
    localparam int AFE_BIT      = 7;
    localparam int SQUARE_WAVE_ENABLE_BIT     = 6;
    localparam int ABE_BIT      = 5;
    localparam int HT_BIT       = 6;
    localparam int WDS_BIT      = 7;
    localparam int WMUL_LSB     = 2;
    localparam int WRES_LSB     = 0;
    localparam int STAT_DES_BIT = 0;
    localparam int STAT_SUP_BIT = 1;

    // reset values, equal to first power-up defaults
    localparam logic [7:0] RST_SEC  = 8'h80;
    localparam logic [7:0] RST_CLK  = 8'h00;
    localparam logic [7:0] RST_CTRL = 8'h80;
    localparam logic [7:0] RST_WDOG = 8'h00;
    localparam logic [7:0] RST_ALM  = 8'h00;
    localparam logic [7:0] RST_HALT = 8'h40;

    // ahb transfer type
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

    typedef struct packed {
        logic       valid;
        logic       write;
        logic [7:0] idx;
    } pud_ahb_req_s;

endpackage

// [rtl/pud_sync.sv]
// two-flop synchroniser for one asynchronous level
`timescale 1ns/100ps
module pud_sync
    import pud_pkg::*;
(
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic d,
    output logic      q
);
    logic meta_r;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta_r <= 1'b0;
            q      <= 1'b0;
        end
        else
        begin
            meta_r <= d;
            q      <= meta_r;
        end
    end
endmodule

// [rtl/pud_rec_timer.sv]
// recovery deselect timer, length picked by select and stop bits at start
`timescale 1ns/100ps
module pud_rec_timer
    import pud_pkg::*;
#(
    parameter int unsigned MID_CYC  = REC_MID_CYC,
    parameter int unsigned LONG_CYC = REC_LONG_CYC
)
(
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic start,
    input  wire logic sel,
    input  wire logic stop,
    output logic      busy
);
    logic [CNT_W-1:0] count_r;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            count_r <= '0;
        else if (start)
        begin
            if (sel)
                count_r <= CNT_W'(REC_SHORT_CYC);
            else if (stop)
                count_r <= CNT_W'(LONG_CYC);
            else
                count_r <= CNT_W'(MID_CYC);
        end
        else if (count_r != '0)
            count_r <= count_r - CNT_W'(1);
    end

    assign busy = (count_r != '0);

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    AST_SHORT_LEN: assert property (start && sel |=> count_r == CNT_W'(REC_SHORT_CYC))
        else $error("short recovery length wrong");
    AST_LONG_LEN: assert property (start && !sel && stop |=> count_r == CNT_W'(LONG_CYC))
        else $error("default recovery length wrong");
    AST_MID_LEN: assert property (start && !sel && !stop |=> count_r == CNT_W'(MID_CYC))
        else $error("mid recovery length wrong");
endmodule

// [rtl/pud_top.sv]
// power-up default loading and recovery deselect block with ahb-lite register slave
// Operation
// - recovery select is bit 7 of clock register 04h, read and write.
// - after supply returns, deselect is extended by the selected recovery time.
// - select 0 stop 0 gives 96-98 ms, stop 1 40-200 ms, select 1 50-2000 us.
// - default recovery is the 40-200 ms range: select clear, stop set.
// - first power-up clears watchdog, frequency test, both alarm enables, square wave, select.
// - first power-up sets oscillator stop, output level and halt-update flag.
// - battery power-up keeps select, stop, level; sets halt flag; clears the rest.
// - watchdog defaults cover steer bit, multiplier field and resolution field.
// - other control bits are undefined after first power-up; left untouched.
// - output level is bit 7, frequency test bit 6 of control register 08h.
//
// Chosen here: register access over AHB-Lite and the register offsets.
`timescale 1ns/100ps
module pud_top
    import pud_pkg::*;
#(
    parameter int unsigned MID_CYC  = REC_MID_CYC,
    parameter int unsigned LONG_CYC = REC_LONG_CYC
)
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        supply_ok_pin,
    input  wire logic        battery_kept_pin,
    output logic             deselect
);
    logic         sup_s;
    logic         batt_s;
    logic         sup_d_r;
    logic         pup;
    logic         first;
    logic         busy;
    logic         deselect_r;
    logic         sel_eff;
    logic         stop_eff;
    logic         wr_ok;
    logic         rd_pend_r;
    logic [31:0]  hrdata_r;
    logic         hreadyout_r;
    logic         hresp_r;
    logic [7:0]   sec_r;
    logic [7:0]   clk_r;
    logic [7:0]   ctrl_r;
    logic [7:0]   wdog_r;
    logic [7:0]   alm_r;
    logic [7:0]   halt_r;
    pud_ahb_req_s req_r;
    pud_ahb_req_s req_nxt;

    pud_sync u_sync_sup
    (
        .clk   (hclk),
        .rst_n (hresetn),
        .d     (supply_ok_pin),
        .q     (sup_s)
    );

    pud_sync u_sync_batt
    (
        .clk   (hclk),
        .rst_n (hresetn),
        .d     (battery_kept_pin),
        .q     (batt_s)
    );

    // power-up event: synchronised supply crossing back above threshold
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            sup_d_r <= 1'b0;
        else
            sup_d_r <= sup_s;
    end

    assign pup   = sup_s && !sup_d_r;
    assign first = !batt_s;

    // the timer sees the values the registers take on this same edge
    assign sel_eff  = first ? 1'b0 : clk_r[REC_SEL_BIT];
    assign stop_eff = first ? 1'b1 : sec_r[OSC_HALT_BIT];

    pud_rec_timer #(
        .MID_CYC  (MID_CYC),
        .LONG_CYC (LONG_CYC)
    ) u_timer
    (
        .clk   (hclk),
        .rst_n (hresetn),
        .start (pup),
        .sel   (sel_eff),
        .stop  (stop_eff),
        .busy  (busy)
    );

    // deselect covers supply loss, the event edge and the whole recovery time
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            deselect_r <= 1'b1;
        else
            deselect_r <= !sup_s || pup || busy;
    end

    // ahb address phase capture
    always_comb
    begin
        req_nxt       = '0;
        req_nxt.valid = hsel && hready && (htrans == HTRANS_NONSEQ || htrans[1]);
        req_nxt.write = hwrite;
        req_nxt.idx   = haddr[9:2];
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            req_r <= '0;
        else if (hready)
            req_r <= req_nxt;
    end

    // a write landing during deselect is dropped without an error response
    assign wr_ok = req_r.valid && req_r.write && !deselect_r;

    // reads take one wait state so read-after-write returns the new value
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            rd_pend_r   <= 1'b0;
            hreadyout_r <= 1'b1;
        end
        else
        begin
            rd_pend_r   <= req_nxt.valid && !req_nxt.write;
            hreadyout_r <= !(req_nxt.valid && !req_nxt.write);
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            hresp_r <= 1'b0;
        else
            hresp_r <= 1'b0;
    end

    function automatic logic [31:0] rd_mux(input logic [7:0] idx);
        logic [7:0] v;
        v = 8'h00;
        case (idx)
            IDX_SEC:  v = sec_r;
            IDX_CLK:  v = clk_r;
            IDX_CTRL: v = ctrl_r;
            IDX_WDOG: v = wdog_r;
            IDX_ALM:  v = alm_r;
            IDX_HALT: v = halt_r;
            IDX_STAT:
            begin
                v[STAT_DES_BIT] = deselect_r;
                v[STAT_SUP_BIT] = sup_s;
            end
            default:  v = 8'h00;
        endcase
        return {24'h000000, v};
    endfunction

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            hrdata_r <= 32'h00000000;
        else if (rd_pend_r)
            hrdata_r <= rd_mux(req_r.idx);
    end

    // oscillator stop bit register
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            sec_r <= RST_SEC;
        else if (pup && first)
            sec_r[OSC_HALT_BIT] <= 1'b1;
        else if (wr_ok && req_r.idx == IDX_SEC)
            sec_r <= hwdata[7:0];
    end

    // clock register holding the recovery select bit
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            clk_r <= RST_CLK;
        else if (pup && first)
            clk_r[REC_SEL_BIT] <= 1'b0;
        else if (wr_ok && req_r.idx == IDX_CLK)
            clk_r <= hwdata[7:0];
    end

    // control register: output level and frequency test; low bits kept (undefined)
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            ctrl_r <= RST_CTRL;
        else if (pup)
        begin
            ctrl_r[FT_BIT] <= 1'b0;
            if (first)
                ctrl_r[OUT_BIT] <= 1'b1;
        end
        else if (wr_ok && req_r.idx == IDX_CTRL)
            ctrl_r <= hwdata[7:0];
    end

    // watchdog: steer, multiplier and resolution all cleared on any power-up
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            wdog_r <= RST_WDOG;
        else if (pup)
            wdog_r <= RST_WDOG;
        else if (wr_ok && req_r.idx == IDX_WDOG)
            wdog_r <= hwdata[7:0];
    end

    // alarm enables and square wave enable; other bits left as they were
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            alm_r <= RST_ALM;
        else if (pup)
        begin
            alm_r[AFE_BIT]  <= 1'b0;
            alm_r[ABE_BIT]  <= 1'b0;
            alm_r[SQUARE_WAVE_ENABLE_BIT] <= 1'b0;
        end
        else if (wr_ok && req_r.idx == IDX_ALM)
            alm_r <= hwdata[7:0];
    end

    // halt-update flag; the power-up set wins over a host clear
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            halt_r <= RST_HALT;
        else if (pup)
            halt_r[HT_BIT] <= 1'b1;
        else if (wr_ok && req_r.idx == IDX_HALT)
            halt_r <= hwdata[7:0];
    end

    assign hrdata    = hrdata_r;
    assign hreadyout = hreadyout_r;
    assign hresp     = hresp_r;
    assign deselect  = deselect_r;

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    AST_SEL_WRITE: assert property (wr_ok && req_r.idx == IDX_CLK && !pup
        |=> clk_r[REC_SEL_BIT] == $past(hwdata[REC_SEL_BIT]))
        else $error("recovery select not written");
    AST_DESEL_RECOVERY: assert property (pup |=> deselect_r [*8])
        else $error("deselect dropped during recovery");
    AST_DESEL_END: assert property (sup_s && !pup && !busy ##1 sup_s |=> !deselect_r)
        else $error("deselect held after recovery");
    AST_DESEL_LOSS: assert property (!sup_s |=> deselect_r)
        else $error("deselect low while supply is down");
    AST_FIRST_CLEAR: assert property (pup && first |=> wdog_r == 8'h00 && !ctrl_r[FT_BIT]
        && !alm_r[AFE_BIT] && !alm_r[ABE_BIT] && !alm_r[SQUARE_WAVE_ENABLE_BIT] && !clk_r[REC_SEL_BIT])
        else $error("first power-up clears missing");
    AST_FIRST_SET: assert property (pup && first
        |=> sec_r[OSC_HALT_BIT] && ctrl_r[OUT_BIT] && halt_r[HT_BIT])
        else $error("first power-up sets missing");
    AST_KEEP_BATT: assert property (pup && !first |=> $stable(clk_r[REC_SEL_BIT])
        && $stable(sec_r[OSC_HALT_BIT]) && $stable(ctrl_r[OUT_BIT]) && halt_r[HT_BIT]
        && !ctrl_r[FT_BIT] && !alm_r[AFE_BIT] && !alm_r[ABE_BIT] && !alm_r[SQUARE_WAVE_ENABLE_BIT])
        else $error("battery power-up defaults wrong");
    AST_WDOG_ZERO: assert property (pup |=> wdog_r[WDS_BIT] == 1'b0
        && wdog_r[6:WMUL_LSB] == 5'h00 && wdog_r[1:WRES_LSB] == 2'h0)
        else $error("watchdog fields not cleared");
    AST_OTHER_BITS: assert property (pup |=> $stable(ctrl_r[5:0]))
        else $error("undefined control bits disturbed");
    AST_NO_WRITE: assert property (deselect_r && !pup |=> $stable(ctrl_r) && $stable(wdog_r))
        else $error("write accepted during deselect");
    AST_READ_WAIT: assert property (req_nxt.valid && !req_nxt.write
        |=> !hreadyout ##1 hreadyout && hrdata == rd_mux($past(req_r.idx)))
        else $error("read answer wrong");

    COV_FIRST_PUP: cover property (pup && first ##1 deselect_r);
    COV_BATT_PUP:  cover property (pup && !first && clk_r[REC_SEL_BIT]);
    COV_WRITE_OK:  cover property (wr_ok && req_r.idx == IDX_CLK);
    COV_SHORT_REC: cover property (pup && sel_eff);
endmodule

// [test/pud_host.sv]
// host model: single-word ahb-lite master transfers
`timescale 1ns/100ps
module pud_host
    import pud_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hready,
    input  wire logic [31:0] hrdata,
    output logic             hsel,
    output logic [31:0]      haddr,
    output logic [1:0]       htrans,
    output logic             hwrite,
    output logic [2:0]       hsize,
    output logic [31:0]      hwdata
);
    initial
    begin
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h5A5A5A5A;
    end

    // entered just after a rising edge; request held until hready is sampled high
    task automatic xfer(input logic w, input logic [7:0] idx, input logic [7:0] d,
                        output logic [7:0] q);
        hsel   <= 1'b1;
        htrans <= HTRANS_NONSEQ;
        hwrite <= w;
        hsize  <= 3'h2;
        haddr  <= {22'h0, idx, 2'h0};
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'h0;
        // an idle data bus still toggles so stale data never looks valid
        hwdata <= w ? {24'h0, d} : ~hwdata;
        do @(posedge hclk); while (hready !== 1'b1);
        q = hrdata[7:0];
    endtask
endmodule

// [test/pud_top_tb.sv]
// self-checking bench for the power-up defaults and recovery block
`timescale 1ns/100ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin miscompares++; \
    $display("[FAIL] %0t got %h exp %h", $time, (a), (b)); end end
module pud_top_tb
    import pud_pkg::*;
;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        supply_ok_pin = 1'b0;
    logic        battery_kept_pin = 1'b0;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        deselect;
    int          miscompares = 0;
    int          n_tests = 0;
    int          seed = 27;
    logic [7:0]  m [0:16];
    logic [7:0]  dm [0:16];
    logic [7:0]  q;
    logic [7:0]  a;
    logic [7:0]  idl [0:6] = '{8'h01, 8'h04, 8'h08, 8'h09, 8'h0A, 8'h0C, 8'h10};
    int          enc [0:3][0:2] = '{'{1, 0, 2500}, '{1, 1, 2500}, '{0, 1, 60}, '{0, 0, 40}};

    always #20 hclk = ~hclk;

    pud_top #(.MID_CYC(40), .LONG_CYC(60)) DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .supply_ok_pin(supply_ok_pin), .battery_kept_pin(battery_kept_pin),
        .deselect(deselect));

    pud_host u_host (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

    task automatic final_report;
        $display("miscompares=%0d n_tests=%0d", miscompares, n_tests);
        if (miscompares == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic rd(input logic [7:0] idx, input logic [7:0] mk);
        u_host.xfer(1'b0, idx, 8'h00, q);
        `CHK(q & mk, m[idx] & mk)
        `CHK(hresp, 1'b0)
        `CHK(hreadyout, 1'b1)
    endtask

    // acc says whether the model expects the write to land
    task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic acc);
        u_host.xfer(1'b1, idx, d, q);
        if (acc && idx inside {8'h01, 8'h04, 8'h08, 8'h09, 8'h0A, 8'h0C})
            m[idx] = d;
    endtask

    task automatic chk_all;
        for (int i = 0; i < 7; i++)
            rd(idl[i], dm[idl[i]]);
    endtask

    task automatic pcyc(input int n, input logic batt);
        int c;
        battery_kept_pin <= batt;
        supply_ok_pin <= 1'b0;
        repeat (4) @(posedge hclk);
        `CHK(deselect, 1'b1)
        wr(8'h04, ~m[4], 1'b0);
        supply_ok_pin <= 1'b1;
        c = 0;
        do
        begin
            @(posedge hclk);
            c++;
        end
        while (deselect !== 1'b0 && c < 5000);
        `CHK(c >= n + 1 && c <= n + 8, 1'b1)
        m[9] = 8'h00;
        m[8][6] = 1'b0;
        m[10][7:5] = 3'h0;
        m[12][6] = 1'b1;
        if (!batt)
        begin
            m[4][7] = 1'b0;
            m[1][7] = 1'b1;
            m[8][7] = 1'b1;
        end
        m[16] = 8'h02;
        chk_all();
    endtask

    initial
    begin
        #(40 * 40000);
        miscompares++;
        final_report();
    end

    initial
    begin
        m = '{default: 8'h00};
        dm = '{default: 8'h00};
        m[1] = RST_SEC;
        m[8] = RST_CTRL;
        m[12] = RST_HALT;
        m[16] = 8'h01;
        dm[1] = 8'h80;
        dm[4] = 8'h80;
        dm[8] = 8'hC0;
        dm[9] = 8'hFF;
        dm[10] = 8'hE0;
        dm[12] = 8'h40;
        dm[16] = 8'h03;
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        chk_all();
        pcyc(60, 1'b0);
        for (int i = 0; i < 16; i++)
        begin
            // q is overwritten by every transfer, so the address lives in a
            a = idl[i % 7];
            if (i % 5 == 4)
                a = 8'h03;
            wr(a, 8'($random(seed)), 1'b1);
            rd(a, (a == 8'h10) ? 8'h03 : 8'hFF);
        end
        for (int k = 0; k < 4; k++)
        begin
            wr(8'h01, {enc[k][1] != 0, 7'($random(seed))}, 1'b1);
            wr(8'h04, {enc[k][0] != 0, 7'($random(seed))}, 1'b1);
            wr(8'h08, 8'($random(seed)), 1'b1);
            wr(8'h09, 8'($random(seed)), 1'b1);
            wr(8'h0A, 8'($random(seed)), 1'b1);
            wr(8'h0C, 8'($random(seed)), 1'b1);
            pcyc(enc[k][2], 1'b1);
        end
        final_report();
    end
endmodule
